// ==== pkg/rss_alu_consts.svh ====
// constants for the rotate / subtract / skip datapath slice
// assumes inclusion by bare name from the package and the design
`ifndef RSS_ALU_CONSTS_SVH
`define RSS_ALU_CONSTS_SVH
`define RSS_DATA_W 8
`define RSS_SET_BYTE 8'hff
`define RSS_ACC_RST 8'h00
`define RSS_NOSKIP_CYCLES 1
`define RSS_SKIP_CYCLES 2
`endif

// ==== pkg/rss_alu_pkg.sv ====
// types for the rotate / subtract / skip datapath slice
// assumes the constants header is on the include path
`include "rss_alu_consts.svh"
package rss_alu_pkg;
    typedef enum logic [4:0] {
        op_none                         = 5'h00,
        op_rotate_left_via_carry_mem    = 5'h01,
        op_rotate_left_via_carry_to_accum = 5'h02,
        op_rotate_right_plain_mem       = 5'h03,
        op_rotate_right_plain_to_accum  = 5'h04,
        op_rotate_right_via_carry_mem   = 5'h05,
        op_rotate_right_via_carry_to_accum = 5'h06,
        op_minus_with_borrow_to_accum   = 5'h07,
        op_minus_with_borrow_to_mem     = 5'h08,
        op_minus_to_accum               = 5'h09,
        op_minus_to_mem                 = 5'h0a,
        op_minus_immediate              = 5'h0b,
        op_decrement_skip_zero_mem      = 5'h0c,
        op_decrement_skip_zero_to_accum = 5'h0d,
        op_increment_skip_zero_mem      = 5'h0e,
        op_increment_skip_zero_to_accum = 5'h0f,
        op_skip_on_bit_set              = 5'h10,
        op_set_byte                     = 5'h11,
        op_set_bit                      = 5'h12,
        op_nibble_exchange_mem          = 5'h13,
        op_nibble_exchange_to_accum     = 5'h14
    } alu_op_t;

    typedef enum logic [0:0] {
        st_exec  = 1'b0,
        st_dummy = 1'b1
    } phase_t;

    // request from the decoder
    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [7:0] mem_data;
        logic [7:0] imm_data;
        logic [2:0] bit_sel;
    } alu_req_t;

    typedef struct packed {
        logic signed_wrap_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } flags_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] acc;
        flags_t flags;
        logic mem_we;
        logic [7:0] mem_wdata;
        logic skip;
        logic busy;
    } alu_state_t;
endpackage : rss_alu_pkg

// ==== hw/rotate_subtract_skip_alu.sv ====
// execution datapath for rotates, subtracts, skip tests, set and nibble exchange
// assumes the sequencer presents one request per cycle while ready is high,
// and supplies the operand byte already read from data memory
`timescale 1ns/1ps
`default_nettype none
`include "rss_alu_consts.svh"
module rotate_subtract_skip_alu
    import rss_alu_pkg::*;
#(
    parameter int DATA_W = `RSS_DATA_W
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire alu_req_t req,
    output logic req_ready,
    output logic [7:0] acc_out,
    output var flags_t flags_out,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    output logic skip_pulse,
    output logic dummy_cycle
);
    alu_state_t state_r;
    alu_state_t state_nxt;

    logic [7:0] m;
    logic c_in;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] addend;
    logic add_cin;
    logic take;
    logic [7:0] bit_mask;

    assign m = req.mem_data;
    assign c_in = state_r.flags.carry_flag;
    // stall the decoder while the discarded fetch is replaced
    assign take = req.valid && (state_r.phase == st_exec);
    assign req_ready = (state_r.phase == st_exec);
    assign bit_mask = 8'h01 << req.bit_sel;

    // every subtract is complement-and-add, so carry out is the inverted borrow
    always_comb begin
        addend = ~m;
        add_cin = 1'b1;
        if (req.op == op_minus_immediate) begin
            addend = ~req.imm_data;
        end
        if (req.op == op_minus_with_borrow_to_accum || req.op == op_minus_with_borrow_to_mem) begin
            add_cin = c_in;
        end
    end
    assign sum = {1'b0, state_r.acc} + {1'b0, addend} + {8'h00, add_cin};
    assign low_sum = {1'b0, state_r.acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, add_cin};

    always_comb begin
        logic [7:0] dec_v;
        logic [7:0] inc_v;
        dec_v = m - 8'h01;
        inc_v = m + 8'h01;
        state_nxt = state_r;
        state_nxt.mem_we = 1'b0;
        state_nxt.skip = 1'b0;
        state_nxt.busy = 1'b0;
        if (state_r.phase == st_dummy) begin
            // prefetched instruction is dropped here
            state_nxt.phase = st_exec;
        end else if (take) begin
            unique case (req.op)
                op_none: begin
                end
                op_rotate_left_via_carry_mem: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = {m[6:0], c_in};
                    state_nxt.flags.carry_flag = m[7];
                end
                op_rotate_left_via_carry_to_accum: begin
                    state_nxt.acc = {m[6:0], c_in};
                    state_nxt.flags.carry_flag = m[7];
                end
                op_rotate_right_plain_mem: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = {m[0], m[7:1]};
                end
                op_rotate_right_plain_to_accum: begin
                    state_nxt.acc = {m[0], m[7:1]};
                end
                op_rotate_right_via_carry_mem: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = {c_in, m[7:1]};
                    state_nxt.flags.carry_flag = m[0];
                end
                op_rotate_right_via_carry_to_accum: begin
                    state_nxt.acc = {c_in, m[7:1]};
                    state_nxt.flags.carry_flag = m[0];
                end
                op_minus_with_borrow_to_accum, op_minus_to_accum, op_minus_immediate,
                op_minus_with_borrow_to_mem, op_minus_to_mem: begin
                    if (req.op == op_minus_with_borrow_to_mem || req.op == op_minus_to_mem) begin
                        state_nxt.mem_we = 1'b1;
                        state_nxt.mem_wdata = sum[7:0];
                    end else begin
                        state_nxt.acc = sum[7:0];
                    end
                    state_nxt.flags.carry_flag = sum[8];
                    state_nxt.flags.half_carry_flag = low_sum[4];
                    state_nxt.flags.zero_flag = (sum[7:0] == 8'h00);
                    state_nxt.flags.signed_wrap_flag =
                        (state_r.acc[7] == addend[7]) && (sum[7] != state_r.acc[7]);
                end
                op_decrement_skip_zero_mem: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = dec_v;
                    state_nxt.skip = (dec_v == 8'h00);
                end
                op_decrement_skip_zero_to_accum: begin
                    state_nxt.acc = dec_v;
                    state_nxt.skip = (dec_v == 8'h00);
                end
                op_increment_skip_zero_mem: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = inc_v;
                    state_nxt.skip = (inc_v == 8'h00);
                end
                op_increment_skip_zero_to_accum: begin
                    state_nxt.acc = inc_v;
                    state_nxt.skip = (inc_v == 8'h00);
                end
                op_skip_on_bit_set: begin
                    state_nxt.skip = |(m & bit_mask);
                end
                op_set_byte: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = `RSS_SET_BYTE;
                end
                op_set_bit: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = m | bit_mask;
                end
                op_nibble_exchange_mem: begin
                    state_nxt.mem_we = 1'b1;
                    state_nxt.mem_wdata = {m[3:0], m[7:4]};
                end
                op_nibble_exchange_to_accum: begin
                    state_nxt.acc = {m[3:0], m[7:4]};
                end
                default: begin
                end
            endcase
            if (state_nxt.skip) begin
                state_nxt.phase = st_dummy;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= '{phase: st_exec, acc: `RSS_ACC_RST, flags: '0,
                         mem_we: 1'b0, mem_wdata: 8'h00, skip: 1'b0, busy: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign acc_out = state_r.acc;
    assign flags_out = state_r.flags;
    assign mem_we = state_r.mem_we;
    assign mem_wdata = state_r.mem_wdata;
    assign skip_pulse = state_r.skip;
    assign dummy_cycle = (state_r.phase == st_dummy);

    sequence s_skip_taken;
        take && state_nxt.skip;
    endsequence
    sequence s_dummy_then_ready;
        dummy_cycle && !req_ready ##1 req_ready;
    endsequence

    a_skip_dummy_cycle: assert property (@(posedge core_clk) disable iff (reset)
        s_skip_taken |=> s_dummy_then_ready)
        else $error("skip did not add exactly one dummy cycle");
    a_noskip_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
        (take && !state_nxt.skip) |=> req_ready)
        else $error("non-skip instruction stalled");
    a_rlc_mem_result: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_rotate_left_via_carry_mem) |=>
        mem_we && mem_wdata == {$past(m[6:0]), $past(c_in)} && flags_out.carry_flag == $past(m[7]))
        else $error("left rotate via carry wrong");
    a_rotate_left_via_carry_to_accum_acc_result: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_rotate_left_via_carry_to_accum) |=>
        !mem_we && acc_out == {$past(m[6:0]), $past(c_in)} && flags_out.zero_flag == $past(flags_out.zero_flag))
        else $error("left rotate to accumulator wrong");
    a_rr_no_flags: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_rotate_right_plain_mem) |=>
        mem_wdata == {$past(m[0]), $past(m[7:1])} && $stable(flags_out))
        else $error("plain right rotate wrong");
    a_rotate_right_via_carry_to_accum_carry_in: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_rotate_right_via_carry_to_accum) |=>
        acc_out[7] == $past(c_in) && flags_out.carry_flag == $past(m[0]))
        else $error("right rotate via carry wrong");
    a_sub_no_borrow: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_minus_to_accum) |=>
        flags_out.carry_flag == ($past(state_r.acc) >= $past(m)))
        else $error("subtract carry is not inverted borrow");
    a_sbc_result: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_minus_with_borrow_to_accum) |=>
        acc_out == 8'($past(state_r.acc) - $past(m) - {7'h00, !$past(c_in)}))
        else $error("subtract with borrow wrong");
    a_dec_skip_zero: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_decrement_skip_zero_mem && m == 8'h01) |=> skip_pulse && mem_wdata == 8'h00)
        else $error("decrement to zero did not skip");
    a_bit_skip: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_skip_on_bit_set) |=> skip_pulse == $past(m[req.bit_sel]))
        else $error("bit test skip wrong");
    a_set_bit_only: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_set_bit) |=> (mem_wdata ^ $past(m)) == ($past(bit_mask) & ~$past(m)))
        else $error("set bit touched other bits");
    a_swap_acc: assert property (@(posedge core_clk) disable iff (reset)
        (take && req.op == op_nibble_exchange_to_accum) |=>
        !mem_we && acc_out == {$past(m[3:0]), $past(m[7:4])})
        else $error("nibble exchange wrong");
endmodule : rotate_subtract_skip_alu
`default_nettype wire

// ==== dv/data_mem_model.sv ====
// data memory byte behind the datapath, fed back as the operand
// assumes the bench preloads it through load before each request
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
    input wire logic core_clk,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_byte
);
    // write-back wins over a preload landing on the same edge
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem_byte <= mem_wdata;
        end else if (load) begin
            mem_byte <= load_val;
        end
    end
endmodule : data_mem_model
`default_nettype wire

// ==== dv/rotate_subtract_skip_alu_tb.sv ====
// self-checking bench for the rotate / subtract / skip datapath
// assumes the datapath registers its answer on the taking edge itself
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_skip_alu_tb;
    import rss_alu_pkg::*;
    logic core_clk, reset, req_ready, mem_we, skip_pulse, dummy_cycle, load;
    logic [7:0] acc_out, mem_wdata, mem_byte, load_val, ea, em;
    flags_t flags_out, ef;
    alu_req_t rq, req;
    int n_fail, tests_run, cyc;

    always_comb begin
        req = rq;
        req.mem_data = mem_byte;
    end

    rotate_subtract_skip_alu i_dut (.core_clk(core_clk), .reset(reset), .req(req),
        .req_ready(req_ready), .acc_out(acc_out), .flags_out(flags_out), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .skip_pulse(skip_pulse), .dummy_cycle(dummy_cycle));
    data_mem_model i_mem (.core_clk(core_clk), .load(load), .load_val(load_val),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_byte(mem_byte));

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] sub(logic [7:0] a, logic [7:0] b, logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
        ef.carry_flag = s[8];
        ef.half_carry_flag = h[4];
        ef.zero_flag = (s[7:0] == 8'h00);
        ef.signed_wrap_flag = (a[7] == ~b[7]) && (s[7] != a[7]);
        return s[7:0];
    endfunction : sub

    task automatic predict(alu_op_t op, logic [7:0] m, logic [7:0] imm, logic [2:0] bs,
                           output logic we, output logic sk);
        logic [7:0] r;
        we = 1'b0;
        sk = 1'b0;
        r = m;
        em = m;
        case (op)
            op_rotate_left_via_carry_mem, op_rotate_left_via_carry_to_accum: begin
                r = {m[6:0], ef.carry_flag};
                ef.carry_flag = m[7];
            end
            op_rotate_right_plain_mem, op_rotate_right_plain_to_accum: r = {m[0], m[7:1]};
            op_rotate_right_via_carry_mem, op_rotate_right_via_carry_to_accum: begin
                r = {ef.carry_flag, m[7:1]};
                ef.carry_flag = m[0];
            end
            op_minus_with_borrow_to_accum, op_minus_with_borrow_to_mem: r = sub(ea, m, ef.carry_flag);
            op_minus_to_accum, op_minus_to_mem: r = sub(ea, m, 1'b1);
            op_minus_immediate: r = sub(ea, imm, 1'b1);
            op_decrement_skip_zero_mem, op_decrement_skip_zero_to_accum: r = m - 8'h01;
            op_increment_skip_zero_mem, op_increment_skip_zero_to_accum: r = m + 8'h01;
            op_set_byte: r = 8'hff;
            op_set_bit: r = m | (8'h01 << bs);
            op_nibble_exchange_mem, op_nibble_exchange_to_accum: r = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (op inside {op_decrement_skip_zero_mem, op_decrement_skip_zero_to_accum,
                       op_increment_skip_zero_mem, op_increment_skip_zero_to_accum}) begin
            sk = (r == 8'h00);
        end
        if (op == op_skip_on_bit_set) begin
            sk = m[bs];
        end
        if (op inside {op_rotate_left_via_carry_to_accum, op_rotate_right_plain_to_accum,
                       op_rotate_right_via_carry_to_accum, op_minus_with_borrow_to_accum,
                       op_minus_to_accum, op_minus_immediate, op_decrement_skip_zero_to_accum,
                       op_increment_skip_zero_to_accum, op_nibble_exchange_to_accum}) begin
            ea = r;
        end else if (op != op_skip_on_bit_set && op != op_none) begin
            we = 1'b1;
            em = r;
        end
    endtask : predict

    task automatic exec(alu_op_t op, logic [7:0] m, logic [7:0] imm, logic [2:0] bs);
        logic we, sk;
        predict(op, m, imm, bs, we, sk);
        load_val = m;
        load = 1'b1;
        @(posedge core_clk);
        #1 load = 1'b0;
        rq = '{1'b1, op, 8'h00, imm, bs};
        @(posedge core_clk);
        // held request during a dummy cycle must not be taken
        // one assignment per time step: valid stays up only when a skip is due
        #1 rq = '{sk, op_set_byte, 8'h00, imm, bs};
        check("acc", acc_out, ea);
        check("flags", {4'h0, flags_out}, {4'h0, ef});
        check("mem_we", {7'h0, mem_we}, {7'h0, we});
        if (we) check("mem_wdata", mem_wdata, em);
        check("skip", {7'h0, skip_pulse}, {7'h0, sk});
        check("dummy", {7'h0, dummy_cycle}, {7'h0, sk});
        check("ready", {7'h0, req_ready}, {7'h0, ~sk});
        @(posedge core_clk);
        #1 rq.valid = 1'b0;
        check("mem", mem_byte, em);
        if (sk) check("refused", {7'h0, mem_we}, 8'h00);
    endtask : exec

    task automatic t_rotates();
        exec(op_rotate_left_via_carry_to_accum, 8'h80, 8'h00, 3'h0);
        exec(op_rotate_left_via_carry_mem, 8'h01, 8'h00, 3'h0);
        exec(op_rotate_right_plain_mem, 8'h01, 8'h00, 3'h0);
        exec(op_rotate_right_plain_to_accum, 8'h02, 8'h00, 3'h0);
        exec(op_rotate_right_via_carry_mem, 8'h01, 8'h00, 3'h0);
        exec(op_rotate_right_via_carry_to_accum, 8'h00, 8'h00, 3'h0);
    endtask : t_rotates

    task automatic t_subtracts();
        exec(op_rotate_left_via_carry_to_accum, 8'h28, 8'h00, 3'h0);
        exec(op_minus_with_borrow_to_accum, 8'h10, 8'h00, 3'h0);
        exec(op_minus_to_accum, 8'h70, 8'h00, 3'h0);
        exec(op_minus_immediate, 8'h00, 8'h4f, 3'h0);
        exec(op_minus_to_mem, 8'h80, 8'h00, 3'h0);
        exec(op_minus_with_borrow_to_mem, 8'h01, 8'h00, 3'h0);
        exec(op_minus_immediate, 8'h00, 8'h81, 3'h0);
    endtask : t_subtracts

    task automatic t_skips();
        exec(op_decrement_skip_zero_mem, 8'h01, 8'h00, 3'h0);
        exec(op_decrement_skip_zero_mem, 8'h00, 8'h00, 3'h0);
        exec(op_decrement_skip_zero_to_accum, 8'h01, 8'h00, 3'h0);
        exec(op_increment_skip_zero_mem, 8'hff, 8'h00, 3'h0);
        exec(op_increment_skip_zero_to_accum, 8'h00, 8'h00, 3'h0);
        exec(op_increment_skip_zero_to_accum, 8'hff, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) exec(op_skip_on_bit_set, 8'ha5, 8'h00, 3'(i));
    endtask : t_skips

    task automatic t_set_swap();
        exec(op_set_byte, 8'h00, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) exec(op_set_bit, 8'h5a, 8'h00, 3'(i));
        exec(op_nibble_exchange_mem, 8'h3c, 8'h00, 3'h0);
        exec(op_nibble_exchange_to_accum, 8'hd2, 8'h00, 3'h0);
        exec(op_none, 8'h77, 8'h00, 3'h0);
    endtask : t_set_swap

    task automatic t_reset();
        load_val = 8'h80;
        load = 1'b1;
        @(posedge core_clk);
        #1 load = 1'b0;
        rq = '{1'b1, op_skip_on_bit_set, 8'h00, 8'h00, 3'h7};
        @(posedge core_clk);
        // reset landing in the dummy cycle must leave the datapath idle and ready
        #1 rq.valid = 1'b0;
        reset = 1'b1;
        #1 check("rst_dummy", {7'h0, dummy_cycle}, 8'h00);
        check("rst_ready", {7'h0, req_ready}, 8'h01);
        check("rst_skip", {7'h0, skip_pulse}, 8'h00);
        check("rst_mem_we", {7'h0, mem_we}, 8'h00);
        check("rst_acc", acc_out, 8'h00);
        check("rst_flags", {4'h0, flags_out}, 8'h00);
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        ea = 8'h00;
        ef = '0;
    endtask : t_reset

    task automatic t_b2b();
        logic we, sk;
        load_val = 8'hc3;
        load = 1'b1;
        @(posedge core_clk);
        #1 load = 1'b0;
        rq = '{1'b1, op_rotate_left_via_carry_to_accum, 8'h00, 8'h00, 3'h0};
        // second take must see the carry left by the first
        repeat (2) begin
            predict(rq.op, 8'hc3, 8'h00, 3'h0, we, sk);
            @(posedge core_clk);
            #1 check("b2b_acc", acc_out, ea);
            check("b2b_carry", {7'h0, flags_out.carry_flag}, {7'h0, ef.carry_flag});
        end
        rq.valid = 1'b0;
    endtask : t_b2b

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // about 130 cycles of traffic; the ceiling leaves ample slack
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        reset = 1'b1;
        rq = '0;
        load = 1'b0;
        load_val = 8'h00;
        ea = 8'h00;
        ef = '0;
        repeat (4) @(posedge core_clk);
        #1 reset = 1'b0;
        t_rotates();
        t_subtracts();
        t_skips();
        t_set_swap();
        t_reset();
        t_b2b();
        summarize();
    end
endmodule : rotate_subtract_skip_alu_tb
`default_nettype wire
